// >>> logic/rmsc_consts.svh
`ifndef RMSC_CONSTS_SVH
`define RMSC_CONSTS_SVH
// function codes
`define RMSC_FC_READ      8'h03
`define RMSC_FC_DIAG      8'h08
`define RMSC_FC_WRITE     8'h10
`define RMSC_FC_EXC_BIT   8'h80
// exception codes, zero means none
`define RMSC_EXC_NONE     8'h00
`define RMSC_EXC_FUNC     8'h01
`define RMSC_EXC_ADDR     8'h02
`define RMSC_EXC_COUNT    8'h03
`define RMSC_EXC_LIMIT    8'h21
`define RMSC_EXC_MANNER   8'h22
`define RMSC_EXC_UNDERV   8'h23
`define RMSC_EXC_BUSY     8'h24
`define RMSC_EXC_CRC      8'h25
// address map
`define RMSC_CMD_LO       16'h0001
`define RMSC_CMD_HI       16'h001F
`define RMSC_CMD_RUN      16'h0001
`define RMSC_CMD_FREQ     16'h0002
`define RMSC_MON_LO       16'h0020
`define RMSC_MON_HI       16'h004F
`define RMSC_TERM_LO      16'h0040
`define RMSC_TERM_HI      16'h004A
`define RMSC_SAVE_CONFIRM 16'h00FF
`define RMSC_GRP_FIRST    8'h01
`define RMSC_GRP_LAST     8'h10
// request limits
`define RMSC_CNT_MIN      16'h0001
`define RMSC_CNT_MAX      16'h0010
// setting codes
`define RMSC_SRC_SERIAL   8'h01
`define RMSC_LOCK_ALL     8'h01
`define RMSC_LOCK_PARAM   8'h02
`endif

// >>> logic/rmsc_pkg.sv
package rmsc_pkg;
  typedef enum logic [1:0] {
    RMSC_IDLE,
    RMSC_WALK,
    RMSC_DONE
  } rmsc_state_t;

  typedef enum logic [2:0] {
    RMSC_REG_CMD,
    RMSC_REG_MON,
    RMSC_REG_SAVE,
    RMSC_REG_PARAM,
    RMSC_REG_RSVD
  } rmsc_region_t;

  typedef struct packed {
    rmsc_state_t st;
    logic [7:0]  func;
    logic [15:0] base;
    logic [4:0]  walkLen;
    logic [4:0]  walkIdx;
    logic [15:0] walkAddr;
    logic        walkActive;
    logic        isWrite;
    logic        errCrc;
    logic        errFunc;
    logic        errAddr;
    logic        errCnt;
    logic        errLim;
    logic        errPerm;
    logic        errUv;
    logic        errBusy;
    logic        saveHit;
    logic        reqReady;
    logic        respValid;
    logic        respExc;
    logic [7:0]  respFunc;
    logic [7:0]  respCode;
    logic        rdValid;
    logic [15:0] rdWord;
    logic        saveStrobe;
  } rmsc_regs_t;
endpackage

// >>> logic/rmsc_addr_decode.sv
`include "rmsc_consts.svh"
module rmsc_addr_decode
  import rmsc_pkg::*;
(
  // address under test
  input  wire logic [15:0] addr,
  // decode result
  output rmsc_region_t     region,
  output logic             termHit
);
  // highest code index of each parameter group page
  function automatic logic [7:0] groupLast(input logic [7:0] hi);
    case (hi)
      8'h01:   groupLast = 8'h13;
      8'h02:   groupLast = 8'h17;
      8'h03:   groupLast = 8'h37;
      8'h04:   groupLast = 8'h24;
      8'h05:   groupLast = 8'h23;
      8'h06:   groupLast = 8'h24;
      8'h07:   groupLast = 8'h12;
      8'h08:   groupLast = 8'h21;
      8'h09:   groupLast = 8'h1C;
      8'h0A:   groupLast = 8'h15;
      8'h0B:   groupLast = 8'h1E;
      8'h0C:   groupLast = 8'h08;
      8'h0D:   groupLast = 8'h17;
      8'h0E:   groupLast = 8'h23;
      8'h0F:   groupLast = 8'h0F;
      8'h10:   groupLast = 8'h0C;
      default: groupLast = 8'h00;
    endcase
  endfunction

  logic [7:0] hiByte;
  logic [7:0] loByte;
  logic       grpOk;

  // high byte is group plus one, low byte the code index
  assign hiByte = addr[15:8];
  assign loByte = addr[7:0];
  assign grpOk  = (hiByte >= `RMSC_GRP_FIRST) && (hiByte <= `RMSC_GRP_LAST);

  always_comb begin
    if (addr >= `RMSC_CMD_LO && addr <= `RMSC_CMD_HI) begin
      region = RMSC_REG_CMD;
    end else if (addr >= `RMSC_MON_LO && addr <= `RMSC_MON_HI) begin
      region = RMSC_REG_MON;
    end else if (addr == `RMSC_SAVE_CONFIRM) begin
      region = RMSC_REG_SAVE;
    end else if (grpOk && loByte <= groupLast(hiByte)) begin
      region = RMSC_REG_PARAM;
    end else begin
      // extension pages and gaps are all reserved
      region = RMSC_REG_RSVD;
    end
  end

  assign termHit = (addr >= `RMSC_TERM_LO) && (addr <= `RMSC_TERM_HI);
endmodule // rmsc_addr_decode

// >>> logic/rmsc_request_checker.sv
`include "rmsc_consts.svh"
module rmsc_request_checker
  import rmsc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // request from the frame receiver
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqFunc,
  input  wire logic [15:0] reqAddr,
  input  wire logic [15:0] reqCount,
  input  wire logic [7:0]  reqByteCount,
  input  wire logic        reqCrcOk,
  output logic             reqReady,
  // per-register attributes for walkAddr, walkIdx
  input  wire logic [15:0] writeData,
  input  wire logic [15:0] attrLow,
  input  wire logic [15:0] attrHigh,
  input  wire logic        attrReadOnly,
  input  wire logic        attrStopOnly,
  input  wire logic [15:0] attrReadWord,
  output logic             walkActive,
  output logic [4:0]       walkIdx,
  output logic [15:0]      walkAddr,
  // drive settings and state
  input  wire logic [7:0]  freq_source_main_setting,
  input  wire logic [7:0]  freq_source_aux_setting,
  input  wire logic [7:0]  run_command_source_setting,
  input  wire logic [7:0]  param_write_lock_setting,
  input  wire logic        motorRunning,
  input  wire logic        nonvolatile_store_fault,
  input  wire logic        supply_undervoltage_state,
  input  wire logic        faultResetting,
  input  wire logic        powerCutoff,
  input  wire logic        savingData,
  input  wire logic [15:0] termStateWord,
  // read data, one word for each register of a read walk that has no address error of its own, even if others in the walk do
  output logic             rdValid,
  output logic [15:0]      rdWord,
  // answer
  output logic             respValid,
  output logic             respExc,
  output logic [7:0]       respFunc,
  output logic [7:0]       respCode,
  output logic             saveStrobe
);
  rmsc_regs_t   s;
  rmsc_regs_t   next_s;
  rmsc_region_t region;
  logic         termHit;

  rmsc_addr_decode u_dec (
    .addr    (s.walkAddr),
    .region  (region),
    .termHit (termHit)
  );

  function automatic logic funcKnown(input logic [7:0] f);
    funcKnown = (f == `RMSC_FC_READ) || (f == `RMSC_FC_DIAG) ||
                (f == `RMSC_FC_WRITE);
  endfunction

  function automatic logic isSerial(input logic [7:0] v);
    isSerial = (v == `RMSC_SRC_SERIAL);
  endfunction

  // fixed priority: crc, function, address, count, limit, manner, undervoltage, busy
  function automatic logic [7:0] excCode(input rmsc_regs_t r);
    if (r.errCrc)       excCode = `RMSC_EXC_CRC;
    else if (r.errFunc) excCode = `RMSC_EXC_FUNC;
    else if (r.errAddr) excCode = `RMSC_EXC_ADDR;
    else if (r.errCnt)  excCode = `RMSC_EXC_COUNT;
    else if (r.errLim)  excCode = `RMSC_EXC_LIMIT;
    else if (r.errPerm) excCode = `RMSC_EXC_MANNER;
    else if (r.errUv)   excCode = `RMSC_EXC_UNDERV;
    else if (r.errBusy) excCode = `RMSC_EXC_BUSY;
    else                excCode = `RMSC_EXC_NONE;
  endfunction

  logic        reqTake;
  logic        reqWalks;
  logic        reqCntBad;
  logic [4:0]  reqLen;
  logic        cmdSel;
  logic        isParam;
  logic        wrNow;
  logic        addrBad;
  logic        limBad;
  logic        permBad;
  logic        uvBad;
  logic        busyBad;
  logic [7:0]  codeNow;

  assign reqTake  = reqValid && s.reqReady;
  // frames with a bad crc or unknown function skip the walk
  assign reqWalks = reqCrcOk && (reqFunc != `RMSC_FC_DIAG) &&
                    funcKnown(reqFunc) && (reqCount != 16'h0000);
  assign reqLen   = (reqCount > `RMSC_CNT_MAX) ? 5'h10 : reqCount[4:0];
  assign reqCntBad = (reqFunc != `RMSC_FC_DIAG) &&
                     ((reqCount < `RMSC_CNT_MIN) ||
                      (reqCount > `RMSC_CNT_MAX) ||
                      ((reqFunc == `RMSC_FC_WRITE) &&
                       ({9'h000, reqByteCount} != {reqCount, 1'b0})));

  always_comb begin
    if (s.walkAddr == `RMSC_CMD_FREQ) begin
      cmdSel = isSerial(freq_source_main_setting) ||
               isSerial(freq_source_aux_setting);
    end else if (s.walkAddr == `RMSC_CMD_RUN) begin
      cmdSel = isSerial(run_command_source_setting);
    end else begin
      cmdSel = 1'b1;
    end
  end

  assign wrNow   = s.walkActive && s.isWrite;
  assign isParam = (region == RMSC_REG_PARAM);
  assign addrBad = s.walkActive && ((region == RMSC_REG_RSVD) ||
                   (!s.isWrite && region == RMSC_REG_SAVE) ||
                   (s.isWrite && region == RMSC_REG_CMD &&
                    !cmdSel));
  assign limBad  = wrNow && (region != RMSC_REG_RSVD) &&
                   (region != RMSC_REG_MON) &&
                   ((writeData < attrLow) ||
                    (writeData > attrHigh));
  assign permBad = wrNow && (nonvolatile_store_fault ||
                   (region == RMSC_REG_MON) ||
                   (isParam && (attrReadOnly ||
                    (motorRunning && attrStopOnly))) ||
                   (isParam &&
                    (param_write_lock_setting == `RMSC_LOCK_ALL ||
                     param_write_lock_setting ==
                     `RMSC_LOCK_PARAM)));
  assign uvBad   = wrNow && isParam && supply_undervoltage_state;
  assign busyBad = wrNow && isParam &&
                   (faultResetting || powerCutoff || savingData);
  assign codeNow = excCode(s);

  always_comb begin
    next_s            = s;
    next_s.respValid  = 1'b0;
    next_s.rdValid    = 1'b0;
    next_s.saveStrobe = 1'b0;
    case (s.st)
      RMSC_IDLE: begin
        if (reqTake) begin
          next_s.func     = reqFunc;
          next_s.base     = reqAddr;
          next_s.walkAddr = reqAddr;
          next_s.walkIdx  = 5'h00;
          next_s.walkLen  = reqLen;
          next_s.isWrite  = (reqFunc == `RMSC_FC_WRITE);
          next_s.errCrc   = !reqCrcOk;
          next_s.errFunc  = !funcKnown(reqFunc);
          next_s.errCnt   = reqCntBad;
          next_s.errAddr  = 1'b0;
          next_s.errLim   = 1'b0;
          next_s.errPerm  = 1'b0;
          next_s.errUv    = 1'b0;
          next_s.errBusy  = 1'b0;
          next_s.saveHit  = 1'b0;
          next_s.reqReady = 1'b0;
          if (reqWalks) begin
            next_s.st         = RMSC_WALK;
            next_s.walkActive = 1'b1;
          end else begin
            next_s.st = RMSC_DONE;
          end
        end
      end
      RMSC_WALK: begin
        // errors accumulate; priority is applied once at the end
        next_s.errAddr = s.errAddr | addrBad;
        next_s.errLim  = s.errLim | limBad;
        next_s.errPerm = s.errPerm | permBad;
        next_s.errUv   = s.errUv | uvBad;
        next_s.errBusy = s.errBusy | busyBad;
        next_s.saveHit = s.saveHit ||
                         (s.isWrite && region == RMSC_REG_SAVE);
        if (!s.isWrite && !addrBad) begin
          next_s.rdValid = 1'b1;
          if (termHit) begin
            next_s.rdWord = {15'h0000,
              termStateWord[s.walkAddr[3:0]]};
          end else begin
            next_s.rdWord = attrReadWord;
          end
        end
        if (s.walkIdx == s.walkLen - 5'h01) begin
          next_s.st         = RMSC_DONE;
          next_s.walkActive = 1'b0;
        end else begin
          next_s.walkIdx  = s.walkIdx + 5'h01;
          next_s.walkAddr = s.walkAddr + 16'h0001;
        end
      end
      RMSC_DONE: begin
        next_s.respValid = 1'b1;
        next_s.respCode  = codeNow;
        next_s.respExc   = (codeNow != `RMSC_EXC_NONE);
        if (codeNow != `RMSC_EXC_NONE) begin
          next_s.respFunc = s.func | `RMSC_FC_EXC_BIT;
        end else begin
          next_s.respFunc   = s.func;
          next_s.saveStrobe = s.saveHit;
        end
        next_s.st       = RMSC_IDLE;
        next_s.reqReady = 1'b1;
      end
      default: begin
        next_s.st         = RMSC_IDLE;
        next_s.walkActive = 1'b0;
        next_s.reqReady   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s          <= '0;
      s.st       <= RMSC_IDLE;
      s.reqReady <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reqReady   = s.reqReady;
  assign walkActive = s.walkActive;
  assign walkIdx    = s.walkIdx;
  assign walkAddr   = s.walkAddr;
  assign rdValid    = s.rdValid;
  assign rdWord     = s.rdWord;
  assign respValid  = s.respValid;
  assign respExc    = s.respExc;
  assign respFunc   = s.respFunc;
  assign respCode   = s.respCode;
  assign saveStrobe = s.saveStrobe;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  unknown_func_a: assert property (
    reqValid && reqReady && reqCrcOk && !funcKnown(reqFunc)
    |-> ##2 respValid && respCode == `RMSC_EXC_FUNC)
    else $error("unknown function not answered with code 1");

  crc_answer_a: assert property (
    reqValid && reqReady && !reqCrcOk
    |-> ##2 respValid && respCode == `RMSC_EXC_CRC)
    else $error("crc failure not answered with code 25");

  zero_count_a: assert property (
    reqValid && reqReady && reqCrcOk &&
    reqFunc == `RMSC_FC_READ && reqCount == 16'h0000
    |-> ##2 respValid && respCode == `RMSC_EXC_COUNT)
    else $error("zero count not answered with code 3");

  byte_count_a: assert property (
    reqValid && reqReady && reqFunc == `RMSC_FC_WRITE &&
    reqCount == 16'h0001 && reqByteCount != 8'h02
    |=> s.errCnt)
    else $error("byte count mismatch not flagged");

  save_read_a: assert property (
    walkActive && !s.isWrite && walkAddr == `RMSC_SAVE_CONFIRM
    |=> s.errAddr)
    else $error("read of save register not refused");

  undervolt_a: assert property (
    walkActive && s.isWrite && region == RMSC_REG_PARAM &&
    supply_undervoltage_state
    |=> s.errUv)
    else $error("undervoltage write not flagged");

  term_bit_a: assert property (
    walkActive && !s.isWrite && termHit
    |=> rdValid &&
        rdWord == {15'h0000, $past(termStateWord[walkAddr[3:0]])})
    else $error("terminal bit read wrong");

  first_error_a: assert property (
    respValid && s.errAddr && !s.errCrc && !s.errFunc
    |-> respCode == `RMSC_EXC_ADDR)
    else $error("address error lost to a later check");

  exc_echo_a: assert property (
    respValid |-> (respExc == (respCode != `RMSC_EXC_NONE)) &&
    respFunc == (respExc ? (s.func | `RMSC_FC_EXC_BIT) : s.func))
    else $error("exception answer does not echo function");

  // a request may be taken on the answer edge, so reqReady is not
  // required to stay high afterwards
  resp_pulse_a: assert property (
    respValid |-> reqReady ##1 !respValid)
    else $error("answer strobe longer than one cycle");

  lock_write_a: assert property (
    walkActive && s.isWrite && region == RMSC_REG_PARAM &&
    param_write_lock_setting == `RMSC_LOCK_PARAM
    |=> s.errPerm)
    else $error("locked parameter write not flagged");
endmodule // rmsc_request_checker

// >>> sim/rmsc_master_model.sv
module rmsc_master_model (
  // clock and handshake
  input  wire logic        core_clk,
  input  wire logic        reqReady,
  // request fields
  output logic             reqValid,
  output logic [7:0]       reqFunc,
  output logic [15:0]      reqAddr,
  output logic [15:0]      reqCount,
  output logic [7:0]       reqByteCount,
  output logic             reqCrcOk,
  // set when a request was never taken
  output logic             lost
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reqValid = 1'b0;
    reqFunc = 8'h00;
    reqAddr = 16'h0000;
    reqCount = 16'h0000;
    reqByteCount = 8'h00;
    reqCrcOk = 1'b1;
    lost = 1'b0;
  end

  function automatic logic [15:0] paramAddr(input logic [7:0] grp,
                                            input logic [7:0] idx);
    return {grp + 8'h01, idx};
  endfunction

  task automatic send(input logic [7:0] f, input logic [15:0] a, c,
                      input logic bcErr, crc);
    int k;
    begin
      @(negedge core_clk);
      reqValid = 1'b1;
      reqFunc = f;
      reqAddr = a;
      reqCount = c;
      reqByteCount = 8'(c << 1) + {7'h00, bcErr};
      reqCrcOk = crc;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (reqReady !== 1'b1 && k < 50);
      if (k >= 50) lost = 1'b1;
      @(negedge core_clk);
      // released lines must not keep the old request alive
      reqValid = 1'b0;
      reqFunc = ~reqFunc;
      reqAddr = ~reqAddr;
      reqCount = ~reqCount;
      reqByteCount = ~reqByteCount;
      reqCrcOk = ~reqCrcOk;
    end
  endtask
endmodule // rmsc_master_model

// >>> sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, sys_rst, reqValid, reqReady, reqCrcOk, lost;
  logic [7:0]  reqFunc, reqByteCount, fMain, fAux, rSrc, lock;
  logic [15:0] reqAddr, reqCount, hiLim, termStateWord, walkAddr, rdWord;
  logic [15:0] loLim, wbase;
  logic [15:0] wd [16];
  logic        ro, so, running, nvf, uv, frst, pcut, saving;
  logic        walkActive, rdValid, respValid, respExc, saveStrobe;
  logic [4:0]  walkIdx;
  logic [7:0]  respFunc, respCode;
  logic [15:0] rdq [$];
  logic [15:0] expq [$];
  int          fail_count, cmp_count, walkCycles;
  // last code index of each parameter group page
  logic [7:0]  grpEnd [16] = '{8'h13, 8'h17, 8'h37, 8'h24, 8'h23, 8'h24,
                               8'h12, 8'h21, 8'h1C, 8'h15, 8'h1E, 8'h08,
                               8'h17, 8'h23, 8'h0F, 8'h0C};

  rmsc_master_model u_master (.core_clk(core_clk), .reqReady(reqReady),
    .reqValid(reqValid), .reqFunc(reqFunc), .reqAddr(reqAddr),
    .reqCount(reqCount), .reqByteCount(reqByteCount),
    .reqCrcOk(reqCrcOk), .lost(lost));

  rmsc_request_checker u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqFunc(reqFunc), .reqAddr(reqAddr),
    .reqCount(reqCount), .reqByteCount(reqByteCount),
    .reqCrcOk(reqCrcOk), .reqReady(reqReady),
    .writeData(wd[walkIdx[3:0]]), .attrLow(loLim), .attrHigh(hiLim),
    .attrReadOnly(ro), .attrStopOnly(so),
    .attrReadWord(walkAddr ^ 16'h5A5A), .walkActive(walkActive),
    .walkIdx(walkIdx), .walkAddr(walkAddr),
    .freq_source_main_setting(fMain), .freq_source_aux_setting(fAux),
    .run_command_source_setting(rSrc), .param_write_lock_setting(lock),
    .motorRunning(running), .nonvolatile_store_fault(nvf),
    .supply_undervoltage_state(uv), .faultResetting(frst),
    .powerCutoff(pcut), .savingData(saving),
    .termStateWord(termStateWord), .rdValid(rdValid), .rdWord(rdWord),
    .respValid(respValid), .respExc(respExc), .respFunc(respFunc),
    .respCode(respCode), .saveStrobe(saveStrobe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (rdValid === 1'b1) rdq.push_back(rdWord);
    if (walkActive === 1'b1) begin
      chk(walkAddr, wbase + 16'(walkCycles));
      chk({11'h000, walkIdx}, 16'(walkCycles));
      walkCycles++;
    end
  end

  task automatic stop_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      cmp_count++;
      if (got !== exp) begin
        fail_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // reference: collect every error class, then pick by priority
  task automatic model(input logic [7:0] f, input logic [15:0] a, c,
                       input logic bcErr, crc,
                       output logic [7:0] code, output logic sv);
    logic ea, el, em, eu, eb, wr, rsv, mon, par;
    logic [15:0] x;
    int n;
    begin
      {ea, el, em, eu, eb, sv} = 6'h00;
      wr = (f == 8'h10);
      expq.delete();
      n = (c > 16'h0010) ? 16 : int'(c);
      for (int i = 0; i < n; i++) begin
        x = a + 16'(i);
        par = x[15:8] >= 8'h01 && x[15:8] <= 8'h10 &&
              x[7:0] <= grpEnd[x[15:8] - 8'h01];
        rsv = x == 16'h0000 || (x > 16'h004F && x < 16'h00FF) ||
              (x > 16'h00FF && !par);
        mon = x >= 16'h0020 && x <= 16'h004F;
        if (!wr) begin
          if (rsv || x == 16'h00FF) ea = 1'b1;
          else if (x >= 16'h0040 && x <= 16'h004A)
            expq.push_back({15'h0000, termStateWord[x[3:0]]});
          else expq.push_back(x ^ 16'h5A5A);
        end else begin
          if (rsv) ea = 1'b1;
          if (x == 16'h0001 && rSrc != 8'h01) ea = 1'b1;
          if (x == 16'h0002 && fMain != 8'h01 && fAux != 8'h01) ea = 1'b1;
          if (!mon && (wd[i] < loLim || wd[i] > hiLim)) el = 1'b1;
          if (mon || nvf) em = 1'b1;
          if (par && (lock == 8'h01 || lock == 8'h02 ||
                      ro || (running && so))) em = 1'b1;
          if (par && uv) eu = 1'b1;
          if (par && (frst || pcut || saving)) eb = 1'b1;
          if (x == 16'h00FF) sv = 1'b1;
        end
      end
      if (!crc) code = 8'h25;
      else if (f != 8'h03 && f != 8'h08 && f != 8'h10) code = 8'h01;
      else if (f == 8'h08) code = 8'h00;
      else if (ea) code = 8'h02;
      else if (c == 16'h0 || c > 16'h10 || (wr && bcErr)) code = 8'h03;
      else if (el) code = 8'h21;
      else if (em) code = 8'h22;
      else if (eu) code = 8'h23;
      else if (eb) code = 8'h24;
      else code = 8'h00;
      sv = sv && code == 8'h00;
    end
  endtask

  task automatic run(input logic [7:0] f, input logic [15:0] a, c,
                     input logic bcErr = 1'b0, crc = 1'b1);
    logic [7:0] code;
    logic sv;
    int k;
    int wexp;
    begin
      model(f, a, c, bcErr, crc, code, sv);
      wexp = (crc && (f == 8'h03 || f == 8'h10) && c != 16'h0000) ?
             ((c > 16'h0010) ? 16 : int'(c)) : 0;
      rdq.delete();
      walkCycles = 0;
      wbase = a;
      u_master.send(f, a, c, bcErr, crc);
      k = 0;
      // look mid-cycle, while the one-cycle answer strobe stands
      while (respValid !== 1'b1 && k < 40) begin
        @(negedge core_clk);
        k++;
      end
      if (k >= 40 || lost) begin
        fail_count++;
        stop_test();
      end
      chk({8'h00, respFunc}, {8'h00, code != 8'h00 ? f | 8'h80 : f});
      chk({8'h00, respCode}, {8'h00, code});
      chk({15'h0000, respExc}, {15'h0000, code != 8'h00});
      chk({15'h0000, saveStrobe}, {15'h0000, sv});
      chk(16'(walkCycles), 16'(wexp));
      if (code == 8'h00 && f == 8'h03) begin
        chk(16'(rdq.size()), 16'(expq.size()));
        foreach (expq[i]) if (i < rdq.size()) chk(rdq[i], expq[i]);
      end
      $display("test done func %h addr %h code %h", f, a, code);
      @(negedge core_clk);
    end
  endtask

  logic [7:0] badF [6] = '{8'h01, 8'h05, 8'h06, 8'h0F, 8'h2B, 8'h90};

  initial begin
    void'($urandom(26303));
    fail_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    {ro, so, running, nvf, uv, frst, pcut, saving} = 8'h00;
    {fMain, fAux, rSrc, lock} = 32'h0000_0000;
    hiLim = 16'h7FFF;
    loLim = 16'h0010;
    termStateWord = 16'($urandom());
    foreach (wd[i]) wd[i] = 16'h0010 + 16'($urandom_range(0, 16'h7000));
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk({15'h0000, reqReady}, 16'h0001);
    chk({15'h0000, respValid}, 16'h0000);
    run(8'h03, 16'h0040, 16'd11);
    run(8'h03, 16'h0020, 16'd16);
    run(8'h03, 16'h0020, 16'd17);
    run(8'h03, 16'h0040, 16'd0);
    run(8'h03, 16'h00FF, 16'd1);
    run(8'h03, 16'h1100, 16'd1);
    run(8'h03, 16'h004F, 16'd2);
    run(8'h03, 16'h0C09, 16'd1);
    run(8'h10, u_master.paramAddr(8'h00, 8'h13), 16'd2);
    foreach (badF[i]) run(badF[i], 16'h0040, 16'd1);
    run(8'h08, 16'h0000, 16'd0);
    run(8'h05, 16'h0000, 16'd1, 1'b0, 1'b0);
    run(8'h10, 16'h0001, 16'd1);
    rSrc = 8'h01;
    run(8'h10, 16'h0001, 16'd1);
    fAux = 8'h01;
    run(8'h10, 16'h0002, 16'd1);
    fAux = 8'h00;
    run(8'h10, 16'h0002, 16'd1);
    run(8'h10, u_master.paramAddr(8'h00, 8'h00), 16'd4, 1'b1);
    wd[1] = 16'h8000;
    run(8'h10, u_master.paramAddr(8'h01, 8'h00), 16'd4);
    run(8'h10, 16'h00FE, 16'd2);
    wd[1] = 16'h0010;
    run(8'h10, 16'h0030, 16'd1);
    for (int j = 0; j < 3; j++) begin
      lock = 8'(j);
      run(8'h10, u_master.paramAddr(8'h02, 8'h05), 16'd3);
    end
    lock = 8'h00;
    running = 1'b1;
    for (int j = 0; j < 3; j++) begin
      {ro, so} = 2'(j);
      run(8'h10, u_master.paramAddr(8'h03, 8'h01), 16'd2);
    end
    {running, ro, so} = 3'b000;
    nvf = 1'b1;
    run(8'h10, 16'h0001, 16'd1);
    nvf = 1'b0;
    uv = 1'b1;
    run(8'h10, u_master.paramAddr(8'h04, 8'h02), 16'd1);
    uv = 1'b0;
    for (int j = 0; j < 3; j++) begin
      {frst, pcut, saving} = 3'(1 << j);
      run(8'h10, u_master.paramAddr(8'h05, 8'h00), 16'd1);
    end
    {frst, pcut, saving} = 3'b000;
    run(8'h10, 16'h00FF, 16'd1);
    // mixed traffic; the small groups are skipped so parameter write walks stay in range
    for (int t = 0; t < 40; t++) begin
      termStateWord = 16'($urandom());
      foreach (wd[i]) wd[i] = 16'($urandom_range(0, 16'h8FFF));
      {running, ro, so, uv, frst} = 5'($urandom_range(0, 31) & 5'h1D);
      loLim = 16'($urandom_range(0, 16'h0100));
      lock = 8'($urandom_range(0, 5) > 2 ? $urandom_range(0, 2) : 0);
      if ($urandom_range(0, 1) == 0)
        run(8'h03, 16'($urandom_range(0, 16'h00F0)),
            16'($urandom_range(0, 17)));
      else
        run(8'h10, u_master.paramAddr(8'($urandom_range(0, 10)),
            8'($urandom_range(0, 8))), 16'($urandom_range(1, 8)));
    end
    stop_test();
  end
endmodule // tb_top
